// >>> pkg/gpw_defs.svh
`ifndef GPW_DEFS_SVH
`define GPW_DEFS_SVH
// register byte addresses (bus address bits 15:0)
`define GPW_OFF_LATCH 16'hfe40
`define GPW_OFF_DIR 16'hfe41
`define GPW_OFF_FUNC 16'hfe42
`define GPW_OFF_PULLZ 16'hfe4f
// additional status and mask registers
`define GPW_OFF_IRQ_STAT 16'hfe50
`define GPW_OFF_IRQ_MASK 16'hfe54
// register reset values
`define GPW_RST_BYTE 8'h00
// field positions in the function control register
`define GPW_FCR_TIMER_SEVEN_TOGGLE_OUT_ENABLE 7
`define GPW_FCR_TIMER_SIX_TOGGLE_OUT_ENABLE 6
`define GPW_FCR_FLAG 5
`define GPW_FCR_IE 4
`define GPW_FCR_CLOCK_OUT_ENABLE 3
// pins that carry alternative outputs
`define GPW_PIN_CLK 5
`define GPW_PIN_T6 6
`define GPW_PIN_T7 7
// clock output divider code for the subclock
`define GPW_CKO_SUB 3'h7
// event bits in the status and mask registers
`define GPW_EV_FLAG 0
`define GPW_EV_WAKE 1
// htrans codes
`define GPW_HTRANS_NONSEQ 2'h2
`endif

// >>> pkg/gpw_pkg.sv
`default_nettype none
package gpw_pkg;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe_n;
    logic [7:0] pu_en;
    logic [7:0] pu_hi_z;
  } gpw_pad_t;
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
  } gpw_req_t;
endpackage : gpw_pkg
`default_nettype wire

// >>> design/gpw_port.sv
`include "gpw_defs.svh"
`default_nettype none
module gpw_port #(
  parameter logic [7:0] OPEN_DRAIN = 8'h00
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic [7:0] pin_i,
  output gpw_pkg::gpw_pad_t pad_q,
  // alternative sources
  input wire logic subclk_i,
  input wire logic timer_six_toggle,
  input wire logic timer_seven_toggle,
  // events
  output logic port_irq_q,
  output logic hold_release_q,
  output logic irq_q
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] port_output_latch_q;
  logic [7:0] port_direction_q;
  logic [7:0] port_function_control_q;
  logic [7:0] pullup_impedance_select_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;
  logic [6:0] div_q;
  logic clk_out_q;
  logic sub_meta_q;
  logic sub_sync_q;
  gpw_pkg::gpw_req_t req_q;
  logic req_vld_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic take = hsel && hready && (htrans == `GPW_HTRANS_NONSEQ);
  wire logic wr_en = req_vld_q && req_q.wr;
  wire logic wr_latch = wr_en && hit(req_q.addr, `GPW_OFF_LATCH);
  wire logic wr_dir = wr_en && hit(req_q.addr, `GPW_OFF_DIR);
  wire logic wr_func = wr_en && hit(req_q.addr, `GPW_OFF_FUNC);
  wire logic wr_pullz = wr_en && hit(req_q.addr, `GPW_OFF_PULLZ);
  wire logic wr_stat = wr_en && hit(req_q.addr, `GPW_OFF_IRQ_STAT);
  wire logic wr_mask = wr_en && hit(req_q.addr, `GPW_OFF_IRQ_MASK);
  wire logic [7:0] wbyte = hwdata[7:0];

  // ----------------------------------------
  // pin logic
  // ----------------------------------------
  // an input bit with its latch set has its pull-up on
  wire logic [7:0] pu_in = ~port_direction_q & port_output_latch_q;
  wire logic flag_set = |(pu_in & ~pin_sync_q);
  wire logic flag_now = port_function_control_q[`GPW_FCR_FLAG];
  wire logic ie_now = port_function_control_q[`GPW_FCR_IE];
  // software may write zero; a set in the same cycle still wins
  wire logic flag_d = flag_set | (wr_func ? wbyte[`GPW_FCR_FLAG] : flag_now);
  wire logic wake_d = flag_d & (wr_func ? wbyte[`GPW_FCR_IE] : ie_now);

  wire logic [2:0] cko_sel = port_function_control_q[2:0];
  wire logic clk_d = (cko_sel == `GPW_CKO_SUB) ? sub_sync_q :
                     (cko_sel == 3'h0) ? ~clk_out_q :
                     div_q[cko_sel];

  logic [7:0] alt;
  always_comb begin
    alt = 8'h00;
    alt[`GPW_PIN_CLK] = port_function_control_q[`GPW_FCR_CLOCK_OUT_ENABLE] & clk_out_q;
    alt[`GPW_PIN_T6] = port_function_control_q[`GPW_FCR_TIMER_SIX_TOGGLE_OUT_ENABLE] & timer_six_toggle;
    alt[`GPW_PIN_T7] = port_function_control_q[`GPW_FCR_TIMER_SEVEN_TOGGLE_OUT_ENABLE] & timer_seven_toggle;
  end

  wire logic [7:0] out_val = port_output_latch_q | alt;
  // open drain bits release the pin instead of driving high
  wire logic [7:0] drive = port_direction_q & ~(OPEN_DRAIN & out_val);

  gpw_pkg::gpw_pad_t pad_d;
  always_comb begin
    pad_d.o = out_val;
    pad_d.oe_n = ~drive;
    pad_d.pu_en = pu_in;
    pad_d.pu_hi_z = pullup_impedance_select_q;
  end

  // ----------------------------------------
  // next register values
  // ----------------------------------------
  // reads other than the latch address, which returns the synchronised pins, see a write landing at the same edge, so no stale byte
  wire logic [7:0] port_output_latch_d =
    wr_latch ? wbyte : port_output_latch_q;
  wire logic [7:0] port_direction_d =
    wr_dir ? wbyte : port_direction_q;
  wire logic [7:0] pullup_impedance_select_d =
    wr_pullz ? wbyte : pullup_impedance_select_q;
  wire logic [7:0] port_function_control_d = {
    wr_func ? wbyte[7:6] : port_function_control_q[7:6],
    flag_d,
    wr_func ? wbyte[4:0] : port_function_control_q[4:0]
  };
  wire logic [1:0] irq_mask_d = wr_mask ? wbyte[1:0] : irq_mask_q;
  wire logic [1:0] stat_d = (irq_stat_q & ~(wr_stat ? wbyte[1:0] : 2'h0)) |
                            {wake_d & ~(ie_now & flag_now), flag_set};

  wire logic [31:0] rdata_d =
    hit(haddr[15:0], `GPW_OFF_LATCH) ? {24'h0, pin_sync_q} :
    hit(haddr[15:0], `GPW_OFF_DIR) ? {24'h0, port_direction_d} :
    hit(haddr[15:0], `GPW_OFF_FUNC) ? {24'h0, port_function_control_d} :
    hit(haddr[15:0], `GPW_OFF_PULLZ) ? {24'h0, pullup_impedance_select_d} :
    hit(haddr[15:0], `GPW_OFF_IRQ_STAT) ? {30'h0, stat_d} :
    hit(haddr[15:0], `GPW_OFF_IRQ_MASK) ? {30'h0, irq_mask_d} : 32'h0;

  // ----------------------------------------
  // bus flip-flops
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_vld_q <= 1'b0;
    end else begin
      req_vld_q <= take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (take) begin
      req_q.addr <= haddr[15:0];
      req_q.wr <= hwrite;
    end
  end

  // read data is taken in the address phase and stands until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  // ----------------------------------------
  // register flip-flops
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_output_latch_q <= `GPW_RST_BYTE;
    end else begin
      port_output_latch_q <= port_output_latch_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_direction_q <= `GPW_RST_BYTE;
    end else begin
      port_direction_q <= port_direction_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_impedance_select_q <= `GPW_RST_BYTE;
    end else begin
      pullup_impedance_select_q <= pullup_impedance_select_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_function_control_q <= `GPW_RST_BYTE;
    end else begin
      port_function_control_q <= port_function_control_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= 2'h0;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= stat_d;
    end
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
    end else begin
      sub_meta_q <= subclk_i;
      sub_sync_q <= sub_meta_q;
    end
  end

  // ----------------------------------------
  // clock output
  // ----------------------------------------
  // runs from hclk, so code 0 gives hclk/2 and code n from 1 to 6 hclk/2^(n+1)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= clk_d;
    end
  end

  // ----------------------------------------
  // output flip-flops
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_irq_q <= 1'b0;
    end else begin
      port_irq_q <= wake_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_release_q <= 1'b0;
    end else begin
      hold_release_q <= wake_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & irq_mask_d);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : gpw_port
`default_nettype wire

// >>> verif/gpw_port_assertions.sv
`default_nettype none
// --
// port checker
// --
module gpw_port_checker (
  // clock
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // pins and events
  input wire logic [7:0] pin_i,
  input wire gpw_pkg::gpw_pad_t pad_q,
  input wire logic port_irq_q,
  input wire logic hold_release_q,
  input wire logic irq_q
);
  logic wr_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel && hready && htrans == 2'h2 && hwrite;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_PULL_INPUT: assert property ((pad_q.pu_en & ~pad_q.oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_WAKE_PAIR: assert property (port_irq_q == hold_release_q)
    else $error("wake and interrupt differ");
  AST_FLAG_HELD: assert property ($fell(port_irq_q) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("flag dropped without a write");
  AST_IRQ_HELD: assert property ($fell(irq_q) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("interrupt dropped without a write");
  AST_FLAG_CAUSE: assert property ($rose(port_irq_q) |-> $past(pin_i, 3) != 8'hff
    || $past(pin_i, 4) != 8'hff || $past(wr_q) || $past(wr_q, 2))
    else $error("flag rose with no low pin");
  AST_CFG_BY_WRITE: assert property ($past(hresetn, 3) && $changed(pad_q[23:0])
    |-> $past(wr_q) || $past(wr_q, 2)) else $error("pad control moved alone");
  AST_LATCH_OUT: assert property ($past(hresetn, 3) && $changed(pad_q.o[4:0])
    |-> $past(wr_q) || $past(wr_q, 2)) else $error("plain pin output moved alone");
  cover property ($rose(port_irq_q));
  cover property ($fell(irq_q));
  cover property ($rose(pad_q.o[7]));
endmodule : gpw_port_checker
bind gpw_port gpw_port_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .pin_i(pin_i), .pad_q(pad_q), .port_irq_q(port_irq_q),
  .hold_release_q(hold_release_q), .irq_q(irq_q));
`default_nettype wire

// >>> verif/gpw_pins.sv
`default_nettype none
module gpw_pins (
  // clock
  input wire logic hclk,
  // pads and board
  input wire gpw_pkg::gpw_pad_t pad_q,
  input wire logic [7:0] ext_low,
  output logic [7:0] pin_i
);
  // an undriven pin with no pull wanders, so a stale level never helps
  logic [7:0] noise_q = 8'h55;
  always @(posedge hclk) noise_q <= ~noise_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_q.oe_n[i]) pin_i[i] = pad_q.o[i];
      else if (ext_low[i]) pin_i[i] = 1'b0;
      else if (pad_q.pu_en[i]) pin_i[i] = 1'b1;
      else pin_i[i] = noise_q[i];
    end
  end
endmodule : gpw_pins
`default_nettype wire

// >>> verif/test_gpw_port.sv
`include "gpw_defs.svh"
`default_nettype none
module test_gpw_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [7:0] pin_i, ext_low = 8'h00;
  logic subclk_i = 1'b0, t6 = 1'b0, t7 = 1'b0, port_irq_q, hold_q, irq_q;
  gpw_pkg::gpw_pad_t pad_q;
  int error_cnt = 0, checks = 0, cyc = 0, n;
  always #2.5 hclk = ~hclk;
  gpw_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
    .pin_i(pin_i), .pad_q(pad_q), .subclk_i(subclk_i),
    .timer_six_toggle(t6), .timer_seven_toggle(t7), .port_irq_q(port_irq_q),
    .hold_release_q(hold_q), .irq_q(irq_q));
  gpw_pins u_pins (.hclk(hclk), .pad_q(pad_q), .ext_low(ext_low),
    .pin_i(pin_i));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(r[7:0], e);
  endtask : rd
  task automatic t_reset();
    chk(pad_q.oe_n, 8'hff);
    rd(`GPW_OFF_DIR, 8'h00);
    rd(`GPW_OFF_FUNC, 8'h00);
    rd(`GPW_OFF_PULLZ, 8'h00);
  endtask : t_reset
  task automatic t_io();
    bus(1'b1, `GPW_OFF_DIR, 8'hff);
    bus(1'b1, `GPW_OFF_LATCH, 8'h3c);
    bus(1'b1, `GPW_OFF_PULLZ, 8'ha5);
    bus(1'b1, 16'hfe44, 8'hff);
    repeat (4) @(posedge hclk);
    chk(pad_q.o, 8'h3c);
    chk(pad_q.oe_n, 8'h00);
    chk(pad_q.pu_hi_z, 8'ha5);
    rd(16'hfe44, 8'h00);
    rd(`GPW_OFF_DIR, 8'hff);
  endtask : t_io
  task automatic t_alt();
    logic p;
    bus(1'b1, `GPW_OFF_LATCH, 8'h00);
    bus(1'b1, `GPW_OFF_FUNC, 8'hc0);
    t6 <= 1'b1;
    t7 <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(pad_q.o, 8'hc0);
    bus(1'b1, `GPW_OFF_LATCH, 8'h40);
    t6 <= 1'b0;
    t7 <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(pad_q.o, 8'h40);
    bus(1'b1, `GPW_OFF_FUNC, 8'h0f);
    subclk_i <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(pad_q.o, 8'h60);
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, `GPW_OFF_FUNC, 8'h08 | c[7:0]);
      repeat (8) @(posedge hclk);
      n = 0;
      p = pad_q.o[5];
      repeat (128) begin
        @(posedge hclk);
        if (pad_q.o[5] && !p) n++;
        p = pad_q.o[5];
      end
      chk(n[7:0], 8'h40 >> c);
    end
  endtask : t_alt
  task automatic t_irq();
    bus(1'b1, `GPW_OFF_DIR, 8'h00);
    bus(1'b1, `GPW_OFF_LATCH, 8'h01);
    // a freshly pulled pin needs pad and synchroniser time to read high
    repeat (8) @(posedge hclk);
    bus(1'b1, `GPW_OFF_FUNC, 8'h10);
    bus(1'b1, `GPW_OFF_IRQ_MASK, 8'h03);
    ext_low <= 8'h02;
    repeat (8) @(posedge hclk);
    chk(pad_q.pu_en, 8'h01);
    rd(`GPW_OFF_FUNC, 8'h10);
    ext_low <= 8'h03;
    for (n = 0; port_irq_q !== 1'b1 && n < 20; n++) @(posedge hclk);
    chk(hold_q, 1'b1);
    rd(`GPW_OFF_FUNC, 8'h30);
    ext_low <= 8'h00;
    bus(1'b1, `GPW_OFF_IRQ_MASK, 8'h00);
    repeat (4) @(posedge hclk);
    chk(irq_q, 1'b0);
    bus(1'b1, `GPW_OFF_IRQ_MASK, 8'h03);
    repeat (4) @(posedge hclk);
    chk(irq_q, 1'b1);
    bus(1'b1, `GPW_OFF_IRQ_STAT, 8'h03);
    repeat (4) @(posedge hclk);
    chk(irq_q, 1'b0);
    rd(`GPW_OFF_FUNC, 8'h30);
    bus(1'b1, `GPW_OFF_FUNC, 8'h10);
    repeat (4) @(posedge hclk);
    chk(port_irq_q, 1'b0);
  endtask : t_irq
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_io();
    t_alt();
    t_irq();
    results();
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
endmodule : test_gpw_port
`default_nettype wire
